// File: common/dss_pkg.sv
// Purpose: Constants for the drive source select and input filter block
// Assumes: 32-bit AHB-Lite register bus, 100 MHz hclk
// Notes: Register offsets are byte addresses of aligned words
// Functional notes
// RULE1: Remote speed source from selector 0..3, default keypad
// RULE2: Keypad source uses presets or typed speed
// RULE3: Terminal source forces preset priority to zero
// RULE4: Analog input used only when function select zero
// RULE5: Serial source takes speed from register 0002H
// RULE6: Host sets preset priority zero for serial/card
// RULE7: Serial command register 0001H drives speed-select inputs
// RULE8: Speed selector 3 without card: error, no run
// RULE9: Remote command source selector 0..3, default terminals
// RULE10: Command selector 3 without card: error, no run
// RULE11: Stop method 0 ramps down on decel ramp
// RULE12: Stop method 1 coasts immediately; default 0
// RULE13: Read mode 0 acts on single sample
// RULE14: Read mode 1 needs two agreeing samples, default
// RULE15: Run indicator lit even with zero speed
// RULE16: Local mode always uses keypad speed
// RULE17: Host removes run before changing selectors
// RULE18: Inputs sampled each fixed scan period
// RULE19: Selectors applied only at a scan boundary
package dss_pkg;
   localparam int DSS_DIN_W = 8;
   localparam int DSS_SPD_W = 16;
   localparam logic [7:0] DSS_CTRL_OFS = 8'h00;
   localparam logic [7:0] DSS_PRIO_OFS = 8'h04;
   localparam logic [7:0] DSS_KEYSPD_OFS = 8'h08;
   localparam logic [7:0] DSS_SERCMD_OFS = 8'h0c;
   localparam logic [7:0] DSS_SERSPD_OFS = 8'h10;
   localparam logic [7:0] DSS_STAT_OFS = 8'h14;
   localparam logic [7:0] DSS_IRQ_OFS = 8'h18;
   localparam logic [7:0] DSS_MASK_OFS = 8'h1c;
   localparam logic [7:0] DSS_REF_OFS = 8'h20;
   // Control register fields
   localparam int DSS_SPDSEL_LSB = 0;
   localparam int DSS_CMDSEL_LSB = 2;
   localparam int DSS_STOP_BIT = 4;
   localparam int DSS_READ_BIT = 5;
   localparam int DSS_KEYMODE_BIT = 6;
   localparam logic [1:0] DSS_SPDSEL_RST = 2'h0;
   localparam logic [1:0] DSS_CMDSEL_RST = 2'h1;
   localparam logic DSS_STOP_RST = 1'b0;
   localparam logic DSS_READ_RST = 1'b1;
   // Interrupt status bits
   localparam int DSS_IRQ_ERR = 0;
   localparam int DSS_IRQ_RUN = 1;
   localparam int DSS_IRQ_STOP = 2;
   localparam int DSS_IRQ_W = 3;
   // Serial speed register and operation command register numbers
   localparam logic [15:0] DSS_MB_CMD_REG = 16'h0001;
   localparam logic [15:0] DSS_MB_SPD_REG = 16'h0002;
   // Scan period
   localparam int DSS_SCAN_NS = 1000;
   localparam int DSS_CLK_NS = 10;
   localparam int DSS_SCAN_CYC = DSS_SCAN_NS / DSS_CLK_NS;
   typedef enum logic [1:0] {
      DSS_SRC_KEY, DSS_SRC_TERM, DSS_SRC_SER, DSS_SRC_CARD
   } dss_src_e;
endpackage : dss_pkg

// File: rtl/dss_in_filter.sv
// Purpose: Scan-rate filter for the digital inputs
// Assumes: din already synchronised to hclk
// Notes: Read mode 1 trades one scan of latency for noise rejection
`timescale 1ns/1ps
module dss_in_filter (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic scan_tick,
   input wire logic read_twice,
   input wire logic [dss_pkg::DSS_DIN_W-1:0] din,
   output logic [dss_pkg::DSS_DIN_W-1:0] dout
);
   import dss_pkg::*;
   logic [DSS_DIN_W-1:0] samp_q;
   logic [DSS_DIN_W-1:0] out_q;
   genvar gi;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         samp_q <= '0;
      end else if (ce && scan_tick) begin
         samp_q <= din; // [RULE18]
      end
   end

   generate
      for (gi = 0; gi < DSS_DIN_W; gi++) begin : g_bit
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               out_q[gi] <= 1'b0;
            end else if (ce && scan_tick) begin
               if (!read_twice) begin
                  out_q[gi] <= din[gi]; // [RULE13]
               end else if (din[gi] == samp_q[gi]) begin
                  out_q[gi] <= din[gi]; // [RULE14]
               end
            end
         end
      end
   endgenerate

   assign dout = out_q;

   read_twice_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && scan_tick && read_twice && din != samp_q |=>
      $stable(dout)) else $error("filter passed unconfirmed input"); // [RULE14]
   read_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && scan_tick && !read_twice |=> dout == $past(din))
      else $error("single read did not pass input"); // [RULE13]
endmodule : dss_in_filter

// File: rtl/dss_source_select.sv
// Purpose: Speed reference and run command source selection
// Assumes: AHB-Lite single word transfers, one slave, zero wait states
// Notes: Selector changes land only at a scan tick
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module dss_source_select (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   input wire logic [dss_pkg::DSS_DIN_W-1:0] din_pin,
   input wire logic [dss_pkg::DSS_SPD_W-1:0] analog1,
   input wire logic [dss_pkg::DSS_SPD_W-1:0] analog2,
   input wire logic [1:0] first_analog_function_sel,
   input wire logic [1:0] second_analog_function_sel,
   input wire logic [dss_pkg::DSS_SPD_W-1:0] card_speed,
   input wire logic card_up,
   input wire logic card_down,
   input wire logic option_slot_present,
   input wire logic local_mode,
   input wire logic key_up,
   input wire logic key_down,
   input wire logic [dss_pkg::DSS_SPD_W-1:0] min_speed,
   input wire logic [8*dss_pkg::DSS_SPD_W-1:0] preset_speeds,
   output logic [dss_pkg::DSS_SPD_W-1:0] speed_ref,
   output logic run_up,
   output logic run_down,
   output logic ramp_stop,
   output logic coast_stop,
   output logic run_led,
   output logic missing_option_error
);
   import dss_pkg::*;
   logic [DSS_DIN_W-1:0] din_s1_q, din_s2_q, din_f;
   logic [7:0] scan_cnt_q;
   logic scan_tick;
   logic [6:0] ctrl_q, act_ctrl_q;
   logic [1:0] prio_q;
   logic [DSS_SPD_W-1:0] keyspd_q, serspd_q;
   logic [DSS_DIN_W-1:0] sercmd_q;
   logic [DSS_IRQ_W-1:0] stat_q, mask_q;
   logic ap_valid_q, ap_write_q;
   logic [7:0] ap_addr_q;
   logic [DSS_SPD_W-1:0] speed_d, speed_q;
   logic up_d, dn_d, up_q, dn_q, err_d, err_q, coast_q, ramp_q;
   logic [DSS_DIN_W-1:0] eff_din;
   logic [1:0] eff_prio;
   dss_src_e spd_src, cmd_src;

   // Preset index from the three speed-select inputs (bits 2..0)
   function automatic logic [DSS_SPD_W-1:0] preset_pick(
         input logic [8*DSS_SPD_W-1:0] tbl, input logic [2:0] idx);
      preset_pick = tbl[idx*DSS_SPD_W +: DSS_SPD_W];
   endfunction : preset_pick

   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] o);
      is_reg = (a == o);
   endfunction : is_reg

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         din_s1_q <= '0;
         din_s2_q <= '0;
      end else if (ce) begin
         din_s1_q <= din_pin;
         din_s2_q <= din_s1_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scan_cnt_q <= '0;
      end else if (ce) begin
         if (scan_tick) begin
            scan_cnt_q <= '0;
         end else begin
            scan_cnt_q <= scan_cnt_q + 8'h01;
         end
      end
   end
   assign scan_tick = (scan_cnt_q == 8'(DSS_SCAN_CYC - 1)); // [RULE18]

   // Serial mode drives the speed-select inputs from the command register
   assign eff_din = (spd_src == DSS_SRC_SER) ? sercmd_q : din_s2_q; // [RULE7]

   dss_in_filter u_filter (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .scan_tick(scan_tick),
      .read_twice(act_ctrl_q[DSS_READ_BIT]),
      .din(eff_din),
      .dout(din_f)
   );

   // AHB-Lite slave, zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_q <= 1'b0;
         ap_write_q <= 1'b0;
         ap_addr_q <= '0;
      end else if (ce && hready) begin
         ap_valid_q <= hsel && htrans[1];
         ap_write_q <= hwrite;
         ap_addr_q <= haddr[7:0];
      end
   end

   logic wr_en;
   assign wr_en = ce && ap_valid_q && ap_write_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= {1'b0, DSS_READ_RST, DSS_STOP_RST, DSS_CMDSEL_RST,
                    DSS_SPDSEL_RST}; // [RULE1] [RULE9] [RULE12] [RULE14]
         prio_q <= '0;
         keyspd_q <= '0;
         sercmd_q <= '0;
         serspd_q <= '0;
         mask_q <= '0;
      end else if (wr_en) begin
         if (is_reg(ap_addr_q, DSS_CTRL_OFS)) ctrl_q <= hwdata[6:0];
         if (is_reg(ap_addr_q, DSS_PRIO_OFS)) prio_q <= hwdata[1:0];
         if (is_reg(ap_addr_q, DSS_KEYSPD_OFS)) keyspd_q <= hwdata[15:0];
         if (is_reg(ap_addr_q, DSS_SERCMD_OFS)) sercmd_q <= hwdata[7:0];
         if (is_reg(ap_addr_q, DSS_SERSPD_OFS)) serspd_q <= hwdata[15:0];
         if (is_reg(ap_addr_q, DSS_MASK_OFS)) mask_q <= hwdata[2:0];
      end
   end

   // Selectors only take effect at a scan edge so no half-switched ref
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act_ctrl_q <= {1'b0, DSS_READ_RST, DSS_STOP_RST, DSS_CMDSEL_RST,
                        DSS_SPDSEL_RST};
      end else if (ce && scan_tick) begin
         act_ctrl_q <= ctrl_q; // [RULE19]
      end
   end

   assign spd_src = local_mode ? DSS_SRC_KEY :
                    dss_src_e'(act_ctrl_q[DSS_SPDSEL_LSB +: 2]); // [RULE16]
   assign cmd_src = dss_src_e'(act_ctrl_q[DSS_CMDSEL_LSB +: 2]);
   // Terminal source forces priority 0; host keeps it 0 for serial/card
   assign eff_prio = (spd_src == DSS_SRC_TERM) ? 2'h0 : prio_q; // [RULE3]

   always_comb begin
      speed_d = '0;
      case (spd_src)
         DSS_SRC_KEY: begin
            if (act_ctrl_q[DSS_KEYMODE_BIT]) begin
               speed_d = keyspd_q; // [RULE2]
            end else begin
               speed_d = preset_pick(preset_speeds, din_f[2:0]); // [RULE2]
            end
         end
         DSS_SRC_TERM: begin
            if (first_analog_function_sel == 2'h0) begin
               speed_d = analog1; // [RULE4]
            end else if (second_analog_function_sel == 2'h0) begin
               speed_d = analog2; // [RULE4]
            end else begin
               speed_d = preset_pick(preset_speeds, din_f[2:0]); // [RULE3]
            end
         end
         DSS_SRC_SER: begin
            if (eff_prio == 2'h0 && din_f[2:0] != 3'h0) begin
               speed_d = preset_pick(preset_speeds, din_f[2:0]); // [RULE7]
            end else begin
               speed_d = serspd_q; // [RULE5]
            end
         end
         DSS_SRC_CARD: begin
            speed_d = card_speed;
         end
         default: begin
            speed_d = '0;
         end
      endcase
   end

   always_comb begin
      up_d = 1'b0;
      dn_d = 1'b0;
      case (cmd_src)
         DSS_SRC_KEY: begin
            up_d = key_up;
            dn_d = key_down;
         end
         DSS_SRC_TERM: begin
            up_d = din_f[6];
            dn_d = din_f[7];
         end
         DSS_SRC_SER: begin
            up_d = sercmd_q[6];
            dn_d = sercmd_q[7];
         end
         DSS_SRC_CARD: begin
            up_d = card_up;
            dn_d = card_down;
         end
         default: begin
            up_d = 1'b0;
         end
      endcase
   end

   assign err_d = !option_slot_present &&
                  ((spd_src == DSS_SRC_CARD) ||
                   (cmd_src == DSS_SRC_CARD)); // [RULE8] [RULE10]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         speed_q <= '0;
         up_q <= 1'b0;
         dn_q <= 1'b0;
         err_q <= 1'b0;
      end else if (ce) begin
         speed_q <= speed_d;
         err_q <= err_d;
         up_q <= up_d && !dn_d && !err_d; // [RULE8] [RULE10]
         dn_q <= dn_d && !up_d && !err_d;
      end
   end

   // Stop style latched when the command drops; cleared in the cycle a
   // run starts so a stop flag never overlaps a running output
   logic run_nx;
   assign run_nx = (up_d ^ dn_d) && !err_d;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ramp_q <= 1'b0;
         coast_q <= 1'b0;
      end else if (ce) begin
         if (run_nx) begin
            ramp_q <= 1'b0;
            coast_q <= 1'b0;
         end else if (up_q || dn_q) begin
            ramp_q <= !act_ctrl_q[DSS_STOP_BIT]; // [RULE11]
            coast_q <= act_ctrl_q[DSS_STOP_BIT]; // [RULE12]
         end
      end
   end

   logic [DSS_IRQ_W-1:0] ev;
   assign ev = {ramp_q | coast_q, up_q | dn_q, err_q};

   // Set wins over write-one-to-clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_q <= '0;
      end else if (ce) begin
         stat_q <= (stat_q & ~((wr_en && is_reg(ap_addr_q, DSS_IRQ_OFS)) ?
                    hwdata[2:0] : 3'h0)) | ev;
      end
   end
   assign irq = |(stat_q & mask_q);

   always_comb begin
      hrdata = 32'h0;
      if (ap_valid_q && !ap_write_q) begin
         case (ap_addr_q)
            DSS_CTRL_OFS: hrdata = {25'h0, ctrl_q};
            DSS_PRIO_OFS: hrdata = {30'h0, eff_prio};
            DSS_KEYSPD_OFS: hrdata = {16'h0, keyspd_q};
            DSS_SERCMD_OFS: hrdata = {24'h0, sercmd_q};
            DSS_SERSPD_OFS: hrdata = {16'h0, serspd_q};
            DSS_STAT_OFS: hrdata = {24'h0, din_f[5:0], err_q, up_q | dn_q};
            DSS_IRQ_OFS: hrdata = {29'h0, stat_q};
            DSS_MASK_OFS: hrdata = {29'h0, mask_q};
            DSS_REF_OFS: hrdata = {16'h0, speed_q};
            default: hrdata = 32'h0;
         endcase
      end
   end

   assign speed_ref = speed_q;
   assign run_up = up_q;
   assign run_down = dn_q;
   assign ramp_stop = ramp_q;
   assign coast_stop = coast_q;
   // Lit with any run command even at zero or sub-minimum speed
   assign run_led = up_q | dn_q; // [RULE15]
   assign missing_option_error = err_q;

   card_error_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && !option_slot_present && act_ctrl_q[1:0] == 2'h3 && !local_mode
      |=> missing_option_error && !run_up && !run_down)
      else $error("missing card did not block run"); // [RULE8]
   cmd_card_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && !option_slot_present && act_ctrl_q[3:2] == 2'h3
      |=> missing_option_error && !run_led)
      else $error("missing card on command source"); // [RULE10]
   serial_ref_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && spd_src == DSS_SRC_SER && din_f[2:0] == 3'h0
      |=> speed_ref == $past(serspd_q))
      else $error("serial speed not used"); // [RULE5]
   local_key_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && local_mode && act_ctrl_q[DSS_KEYMODE_BIT]
      |=> speed_ref == $past(keyspd_q))
      else $error("local mode ignored keypad"); // [RULE16]
   term_prio_a: assert property (@(posedge hclk) disable iff (!hresetn)
      spd_src == DSS_SRC_TERM |-> eff_prio == 2'h0)
      else $error("priority not forced"); // [RULE3]
   sel_boundary_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !scan_tick |=> $stable(act_ctrl_q))
      else $error("selector moved off scan edge"); // [RULE19]
   run_led_a: assert property (@(posedge hclk) disable iff (!hresetn)
      run_up && speed_ref < min_speed |-> run_led)
      else $error("run led dark"); // [RULE15]
   coast_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      coast_stop |-> !ramp_stop && !run_up && !run_down)
      else $error("coast overlaps run"); // [RULE12]
   ramp_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && (run_up || run_down) && !up_d && !dn_d &&
      !act_ctrl_q[DSS_STOP_BIT] |=> ramp_stop)
      else $error("ramp stop not flagged"); // [RULE11]
   analog1_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && spd_src == DSS_SRC_TERM && first_analog_function_sel == 2'h0
      |=> speed_ref == $past(analog1))
      else $error("analog input not used"); // [RULE4]
   scan_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && scan_tick |=> !scan_tick)
      else $error("scan period broken"); // [RULE18]
   run_c: cover property (@(posedge hclk) run_up ##[1:20] ramp_stop);
   coast_c: cover property (@(posedge hclk) run_down ##1 coast_stop);
   err_c: cover property (@(posedge hclk) missing_option_error);
   irq_c: cover property (@(posedge hclk) irq);
endmodule : dss_source_select

// File: bench/dss_ctrl_model.sv
// Purpose: Elevator controller model driving the terminal inputs
// Assumes: Terminal map bit6 up, bit7 down, bits2:0 speed select
// Notes: Changes land just after a rising edge, like real wiring
`timescale 1ns/1ps
module dss_ctrl_model (
   input wire logic hclk,
   input wire logic up,
   input wire logic down,
   input wire logic [2:0] sel,
   output logic [dss_pkg::DSS_DIN_W-1:0] din_pin
);
   import dss_pkg::*;
   // Spare bits are held low so they never look like a command
   always @(posedge hclk) begin
      din_pin <= {down, up, 3'h0, sel};
   end
endmodule : dss_ctrl_model

// File: bench/testbench.sv
// Purpose: Self-checking bench for source select and input filter
// Assumes: Zero wait state AHB-Lite slave, scan tick every 100 cycles
// Notes: Settling waits are whole scans so the filter can catch up
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
   n_fail++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module testbench;
   import dss_pkg::*;
   logic hclk, hresetn, hwrite, hready, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, fn1, fn2;
   logic [15:0] an1, an2, card_spd, min_spd, spd;
   logic [127:0] presets;
   logic card_up, card_down, slot, local_mode, up, down, key_up;
   logic run_up, run_down, ramp_stop, coast_stop, run_led, err, seen;
   logic [2:0] sel;
   logic [7:0] din;
   int n_fail = 0;
   int n_tests = 0;
   assign hready = hreadyout;
   dss_ctrl_model ctrl_u (.hclk(hclk), .up(up), .down(down), .sel(sel),
      .din_pin(din));
   dss_source_select dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .din_pin(din),
      .analog1(an1), .analog2(an2), .first_analog_function_sel(fn1),
      .second_analog_function_sel(fn2), .card_speed(card_spd),
      .card_up(card_up), .card_down(card_down),
      .option_slot_present(slot), .local_mode(local_mode),
      .key_up(key_up), .key_down(1'b0), .min_speed(min_spd),
      .preset_speeds(presets), .speed_ref(spd), .run_up(run_up),
      .run_down(run_down), .ramp_stop(ramp_stop), .coast_stop(coast_stop),
      .run_led(run_led), .missing_option_error(err));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task automatic results;
      $display("TB counts: %0d compares, %0d mismatches", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results
   // Mid-cycle samples equal what the next rising edge sees, without
   // racing the slave's own update at that edge
   task automatic wait_rdy;
      int i;
      logic rdy;
      rdy = 1'b0;
      for (i = 0; i < 50 && !rdy; i++) begin
         @(negedge hclk);
         rdy = (hready === 1'b1);
         rd = hrdata;
         @(posedge hclk);
      end
      if (!rdy) begin
         n_fail++;
         results();
      end
   endtask : wait_rdy
   // One single transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge hclk);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic scans(input int n);
      repeat (n * DSS_SCAN_CYC) @(posedge hclk);
   endtask : scans
   // Pulses up for exactly one scan and reports whether a run appeared
   task automatic pulse_up(output logic hit);
      hit = 1'b0;
      up <= 1'b1;
      repeat (DSS_SCAN_CYC) @(posedge hclk);
      up <= 1'b0;
      repeat (4 * DSS_SCAN_CYC) begin
         @(posedge hclk);
         if (run_up === 1'b1) hit = 1'b1;
      end
   endtask : pulse_up
   initial begin
      #500000;
      n_fail++;
      results();
   end
   initial begin
      hresetn = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0;
      hwdata = '0; an1 = '0; an2 = '0; fn1 = 2'h1; fn2 = 2'h1;
      card_spd = '0; card_up = 1'b0; card_down = 1'b0; slot = 1'b0;
      local_mode = 1'b0; up = 1'b0; down = 1'b0; sel = '0; key_up = 1'b0;
      min_spd = 16'h0100; presets = {16'h3333, 16'h0, 16'h0, 16'h0,
         16'h3030, 16'h2222, 16'h1111, 16'h0000};
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, DSS_CTRL_OFS, 0);
      `CHK("ctrl reset", 32'h00000024, rd)
      bus(1'b0, 8'h3c, 0);
      `CHK("unmapped", 32'h0, rd)
      `CHK("okay resp", 1'b0, hresp)
      $display("TB test defaults done");
      wr(DSS_KEYSPD_OFS, 32'h0321);
      wr(DSS_CTRL_OFS, 32'h64);
      scans(3);
      `CHK("typed speed", 16'h0321, spd)
      wr(DSS_PRIO_OFS, 32'h3);
      local_mode <= 1'b1;
      an1 <= 16'h0abc; fn1 <= 2'h0;
      wr(DSS_CTRL_OFS, 32'h65);
      scans(3);
      `CHK("local speed", 16'h0321, spd)
      local_mode <= 1'b0;
      scans(3);
      `CHK("analog1 speed", 16'h0abc, spd)
      bus(1'b0, DSS_PRIO_OFS, 0);
      `CHK("prio forced", 32'h0, rd[1:0])
      fn1 <= 2'h1; an2 <= 16'h0def; fn2 <= 2'h0;
      scans(3);
      `CHK("analog2 speed", 16'h0def, spd)
      fn2 <= 2'h1;
      $display("TB test sources done");
      wr(DSS_MASK_OFS, 32'h2);
      up <= 1'b1;
      scans(4);
      `CHK("run zero spd", 2'b11, {run_up, run_led})
      `CHK("irq run", 1'b1, irq)
      up <= 1'b0;
      scans(4);
      `CHK("ramp stop", 3'b010, {run_up, ramp_stop, coast_stop})
      wr(DSS_IRQ_OFS, 32'h7);
      @(negedge hclk);
      `CHK("irq clear", 1'b0, irq)
      wr(DSS_CTRL_OFS, 32'h75);
      up <= 1'b1;
      scans(4);
      up <= 1'b0;
      scans(4);
      `CHK("coast stop", 3'b001, {run_up, ramp_stop, coast_stop})
      pulse_up(seen);
      `CHK("read twice", 1'b0, seen)
      wr(DSS_CTRL_OFS, 32'h55);
      scans(2);
      pulse_up(seen);
      `CHK("read once", 1'b1, seen)
      $display("TB test run and filter done");
      wr(DSS_PRIO_OFS, 32'h0);
      wr(DSS_SERSPD_OFS, 32'h0777);
      wr(DSS_SERCMD_OFS, 32'h0);
      wr(DSS_CTRL_OFS, 32'h6a);
      scans(3);
      `CHK("serial speed", 16'h0777, spd)
      wr(DSS_SERCMD_OFS, 32'h83);
      scans(4);
      `CHK("serial preset", 16'h3030, spd)
      `CHK("serial down", 1'b1, run_down)
      wr(DSS_SERCMD_OFS, 32'h0);
      scans(4);
      $display("TB test serial done");
      wr(DSS_CTRL_OFS, 32'h60);
      key_up <= 1'b1;
      scans(3);
      `CHK("keypad run", 17'h10321, {run_up, spd})
      key_up <= 1'b0;
      scans(1);
      $display("TB test keypad done");
      card_spd <= 16'h0cad; slot <= 1'b1;
      wr(DSS_CTRL_OFS, 32'h6f);
      card_up <= 1'b1;
      scans(3);
      `CHK("card run", 18'h0cad << 2 | 18'h2, {spd, run_up, err})
      slot <= 1'b0;
      scans(3);
      `CHK("card gone", 2'b01, {run_up, err})
      card_up <= 1'b0;
      wr(DSS_CTRL_OFS, 32'h6c);
      card_up <= 1'b1;
      scans(3);
      `CHK("cmd card err", 2'b01, {run_up, err})
      card_up <= 1'b0;
      wr(DSS_CTRL_OFS, 32'h67);
      up <= 1'b1;
      scans(3);
      `CHK("spd card err", 2'b01, {run_up, err})
      up <= 1'b0;
      $display("TB test option card done");
      results();
   end
endmodule : testbench
